// [cba_device.sv]
/*
  Converter end: free-running divider, charge-balance flip-flop, count
  pulse gating, single-slope control, pulse-width link receiver with
  control and DAC registers, trigger latch and overload pass-through.
  Assumes the host end of cba_link_if and analog comparators that are
  already synchronous to mclk.
*/
`timescale 1ns/1ps
module cba_device #(
  parameter int ONE_MIN_CYC    = cba_pkg::ONE_MIN_CYC,    // Zero/one split
  parameter int STROBE_MIN_CYC = cba_pkg::STROBE_MIN_CYC  // One/strobe split
) (
  input  wire logic        mclk,             // System clock
  input  wire logic        rst_n,            // Async reset, active low
  cba_link_if.dev          lnk,              // Link to host
  input  wire logic        cb_comp_above,    // Integrator above threshold
  input  wire logic        ss_comp_positive, // Integrator still positive
  input  wire logic        ext_trigger_n,    // External trigger, low active
  input  wire logic        overload_detect,  // Source current over limit
  output logic             cb_inject,        // Balancing current on
  output logic             input_connect,    // Input and balance path on
  output logic             ss_current_on,    // Single-slope current on
  output logic [1:0]       mux_sel,          // Phase multiplexer select
  output logic [3:0]       gain_sel,         // Ranging amplifier gain
  output logic [7:0]       range_relays,     // Preamplifier relays
  output logic [11:0]      dac_code,         // Voltage source DAC word
  output logic             word_error        // Malformed frame, pulse
);
  initial begin
    if (STROBE_MIN_CYC >= (1 << cba_pkg::WCNT_W) || ONE_MIN_CYC >= STROBE_MIN_CYC)
      $error("cba_device: bad pulse width split");
  end

  localparam int TB = cba_pkg::TAP_BASE;

  // Free-running divider and taps
  logic [cba_pkg::DIV_W-1:0] div_q, div_d;   // Divider count
  logic                      t1_q, t3_q;     // Previous tap levels
  logic                      tap1, tap2, tap3, tap4;
  logic                      tap1_rise, tap3_rise;
  logic                      term_gate_n;    // Low ends injection

  assign tap1        = div_q[TB];
  assign tap2        = div_q[TB + 1];
  assign tap3        = div_q[TB + 2];
  assign tap4        = div_q[TB + 3];
  assign tap1_rise   = tap1 && !t1_q;
  assign tap3_rise   = tap3 && !t3_q;
  assign term_gate_n = !(tap2 && tap3 && tap4);

  // Control word fields in use
  logic [cba_pkg::CTRL_W-1:0] ctrl_q, ctrl_d;  // Strobed control word
  logic [cba_pkg::DAC_W-1:0]  dac_q, dac_d;    // Strobed DAC word
  logic                       en_in;           // Input enabled
  logic                       ss_mode;         // Single-slope phase
  logic                       cb_phase;        // Charge-balance phase

  assign en_in    = ctrl_q[cba_pkg::F_ENABLE];
  assign ss_mode  = ctrl_q[cba_pkg::F_SSLOPE];
  // Balance only runs once the host has enabled the input
  assign cb_phase = en_in && !ss_mode;

  // Converter core next values
  logic cb_q, cb_d;       // Charge-balance flip-flop
  logic cnt_q, cnt_d;     // Registered count pulse
  always_comb begin
    div_d = div_q + cba_pkg::DIV_W'(1);
    cb_d  = cb_q;
    if (!cb_phase)
      cb_d = 1'b0;        // Balance current never outside its phase
    else if (tap3_rise && cb_comp_above)
      cb_d = 1'b1;        // Set wins over the terminate gate
    else if (!term_gate_n)
      cb_d = 1'b0;
    // One pulse per tap one rise while the active gate is open
    cnt_d = tap1_rise && ((cb_phase && cb_q) ||
                          (ss_mode && ss_comp_positive));
  end

  // Converter core registers
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n)
    begin
      div_q <= '0;
      t1_q  <= 1'b0;
      t3_q  <= 1'b0;
      cb_q  <= 1'b0;
      cnt_q <= 1'b0;
    end
    else
    begin
      div_q <= div_d;
      t1_q  <= tap1;
      t3_q  <= tap3;
      cb_q  <= cb_d;
      cnt_q <= cnt_d;
    end
  end

  assign lnk.count_pulse = cnt_q;

  // Link receiver: measure each high pulse, classify at its fall
  logic                        a_q;             // Previous line a level
  logic [cba_pkg::WCNT_W-1:0]  w_q, w_d;        // Current pulse width
  logic [cba_pkg::CTRL_W-1:0]  sh_q, sh_d;      // Received bits
  logic [cba_pkg::NBITS_W-1:0] nb_q, nb_d;      // Bits received
  logic                        err_d;           // Bad frame seen
  logic                        a_fall;

  assign a_fall = a_q && !lnk.ctrl_link_line_a;

  always_comb begin
    w_d    = w_q;
    sh_d   = sh_q;
    nb_d   = nb_q;
    ctrl_d = ctrl_q;
    dac_d  = dac_q;
    err_d  = 1'b0;
    if (lnk.ctrl_link_line_a)
    begin
      // Saturate so a stuck line reads as a strobe, not a wrap
      if (w_q != '1)
        w_d = w_q + cba_pkg::WCNT_W'(1);
    end
    else
      w_d = '0;
    if (a_fall)
    begin
      if (w_q >= cba_pkg::WCNT_W'(STROBE_MIN_CYC))
      begin
        // Strobe: line b picks the target register
        nb_d = '0;
        if (lnk.ctrl_link_line_b && nb_q == cba_pkg::NBITS_W'(cba_pkg::DAC_W))
          dac_d = sh_q[cba_pkg::CTRL_W-1 -: cba_pkg::DAC_W];
        else if (!lnk.ctrl_link_line_b &&
                 nb_q == cba_pkg::NBITS_W'(cba_pkg::CTRL_W))
          ctrl_d = sh_q;
        else
          err_d = 1'b1;   // Wrong bit count: word dropped
      end
      else
      begin
        // Data bit, LSB first, shifted in from the top
        sh_d = {(w_q >= cba_pkg::WCNT_W'(ONE_MIN_CYC)),
                sh_q[cba_pkg::CTRL_W-1:1]};
        if (nb_q != '1)
          nb_d = nb_q + cba_pkg::NBITS_W'(1);
      end
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n)
    begin
      a_q        <= 1'b0;
      w_q        <= '0;
      sh_q       <= '0;
      nb_q       <= '0;
      ctrl_q     <= cba_pkg::CTRL_RESET;
      dac_q      <= '0;
      word_error <= 1'b0;
    end
    else
    begin
      a_q        <= lnk.ctrl_link_line_a;
      w_q        <= w_d;
      sh_q       <= sh_d;
      nb_q       <= nb_d;
      ctrl_q     <= ctrl_d;
      dac_q      <= dac_d;
      word_error <= err_d;
    end
  end

  // Trigger latch and overload flag
  logic trig_q, trig_d;   // Latched trigger
  logic ovl_q;            // Registered overload
  always_comb begin
    trig_d = trig_q;
    if (!ext_trigger_n)
      trig_d = 1'b1;      // Set wins over a clear in the same cycle
    else if (lnk.trigger_clear_out)
      trig_d = 1'b0;
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n)
    begin
      trig_q <= 1'b0;
      ovl_q  <= 1'b0;
    end
    else
    begin
      trig_q <= trig_d;
      ovl_q  <= overload_detect;
    end
  end

  assign lnk.trigger_sense_in   = trig_q;
  assign lnk.source_overload_in = ovl_q;

  // Analog controls from the balance flip-flop and the strobed words
  assign cb_inject     = cb_q;
  assign input_connect = cb_phase;
  assign ss_current_on = ss_mode;
  // Host walks common, reference, signal through this field
  assign mux_sel       = ctrl_q[cba_pkg::F_PHASE_LSB +: cba_pkg::F_PHASE_W];
  assign gain_sel      = ctrl_q[cba_pkg::F_GAIN_LSB +: cba_pkg::F_GAIN_W];
  assign range_relays  = ctrl_q[cba_pkg::F_RANGE_LSB +: cba_pkg::F_RANGE_W];
  assign dac_code      = dac_q;
endmodule : cba_device

// [cba_host.sv]
/*
  Host end: serialises control and DAC words onto the link, counts returned
  pulses, times the charge-balance phase, clears the trigger latch and
  flashes the source indicator on overload.
  Assumes the converter end of cba_link_if on the far side.
*/
`timescale 1ns/1ps
module cba_host #(
  parameter int ONE_CYC    = cba_pkg::ONE_CYC,     // Long bit width
  parameter int STROBE_CYC = cba_pkg::STROBE_CYC,  // Strobe width
  parameter int LINE60_CYC = cba_pkg::LINE60_CYC,  // 60 Hz line period
  parameter int LINE50_CYC = cba_pkg::LINE50_CYC,  // 50 Hz line period
  parameter int FLASH_CYC  = 25000000              // Half flash period
) (
  input  wire logic        mclk,            // System clock
  input  wire logic        rst_n,           // Async reset, active low
  cba_link_if.host         lnk,             // Link to converter
  input  wire logic        cmd_valid,       // Word offered
  output logic             cmd_ready,       // Serialiser idle
  input  wire logic        cmd_dac,         // Word targets the DAC
  input  wire logic [15:0] cmd_data,        // Word, LSB sent first
  input  wire logic        phase_start,     // Clear counters, start phase
  input  wire logic        cb_timed,        // Time a charge-balance phase
  input  wire logic        line_50hz,       // Mains is 50 Hz
  output logic             cb_active,       // Line period running
  output logic             cb_done,         // Line period ended, pulse
  output logic [23:0]      phase_count,     // Pulses counted this phase
  input  wire logic        trig_ack,        // Clear the trigger latch, held off in cal
  output logic             trig_seen,       // Latched trigger state
  input  wire logic        cal_mode,        // Calibration in progress
  input  wire logic        cal_jumper,      // Jumper level, sensed in cal
  output logic             cal_enabled,     // Jumper state captured in cal
  input  wire logic        measure_done,    // Conversion cycle complete
  output logic             end_of_measure_out, // Inverted end pulse
  output logic             source_led       // Source indicator drive
);
  localparam int TW = 22;  // Width of width and line timers
  initial begin
    if (STROBE_CYC >= (1 << TW) || LINE50_CYC >= (1 << TW) || LINE60_CYC >= (1 << TW))
      $error("cba_host: timer width too small");
    // The flash timer is 25 bits wide
    if (FLASH_CYC < 1 || FLASH_CYC > (1 << 25))
      $error("cba_host: flash period out of range");
  end

  // Serialiser: Gray codes along idle, pulse, gap
  typedef enum logic [1:0] {
    CBA_S_IDLE  = 2'b00,
    CBA_S_PULSE = 2'b01,
    CBA_S_GAP   = 2'b11
  } cba_ser_t;

  cba_ser_t                   st_q, st_d;       // Serialiser state
  logic [TW-1:0]              tmr_q, tmr_d;     // Cycles left in pulse/gap
  logic [cba_pkg::CTRL_W-1:0] sh_q, sh_d;       // Bits still to send
  logic [cba_pkg::NBITS_W-1:0] left_q, left_d;  // Bits left; 0 means strobe
  logic                       tgt_q, tgt_d;     // Line b level
  logic                       a_q, a_d;         // Line a level

  assign cmd_ready            = (st_q == CBA_S_IDLE);
  assign lnk.ctrl_link_line_a = a_q;
  assign lnk.ctrl_link_line_b = tgt_q;

  // Next values of the serialiser
  always_comb begin
    st_d   = st_q;
    tmr_d  = tmr_q;
    sh_d   = sh_q;
    left_d = left_q;
    tgt_d  = tgt_q;
    a_d    = a_q;
    unique case (st_q)
      CBA_S_IDLE:
      begin
        if (cmd_valid)
        begin
          sh_d   = cmd_data;
          tgt_d  = cmd_dac;
          left_d = cmd_dac ? cba_pkg::NBITS_W'(cba_pkg::DAC_W)
                           : cba_pkg::NBITS_W'(cba_pkg::CTRL_W);
          // First bit: LSB first, long for one, short for zero
          tmr_d  = cmd_data[0] ? TW'(ONE_CYC) : TW'(cba_pkg::ZERO_CYC);
          a_d    = 1'b1;
          st_d   = CBA_S_PULSE;
        end
      end
      CBA_S_PULSE:
      begin
        if (tmr_q > TW'(1))
          tmr_d = tmr_q - TW'(1);
        else
        begin
          // Line idles low for one short width between pulses
          a_d   = 1'b0;
          tmr_d = TW'(cba_pkg::ZERO_CYC);
          st_d  = CBA_S_GAP;
        end
      end
      CBA_S_GAP:
      begin
        if (tmr_q > TW'(1))
          tmr_d = tmr_q - TW'(1);
        else if (left_q == '0)
          st_d = CBA_S_IDLE;   // Strobe already sent
        else
        begin
          left_d = left_q - cba_pkg::NBITS_W'(1);
          sh_d   = sh_q >> 1;
          a_d    = 1'b1;
          if (left_q == cba_pkg::NBITS_W'(1))
            tmr_d = TW'(STROBE_CYC);
          else
            tmr_d = sh_q[1] ? TW'(ONE_CYC) : TW'(cba_pkg::ZERO_CYC);
          st_d = CBA_S_PULSE;
        end
      end
      default: st_d = CBA_S_IDLE;
    endcase
  end

  // Serialiser registers
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n)
    begin
      st_q   <= CBA_S_IDLE;
      tmr_q  <= '0;
      sh_q   <= '0;
      left_q <= '0;
      tgt_q  <= 1'b0;
      a_q    <= 1'b0;
    end
    else
    begin
      st_q   <= st_d;
      tmr_q  <= tmr_d;
      sh_q   <= sh_d;
      left_q <= left_d;
      tgt_q  <= tgt_d;
      a_q    <= a_d;
    end
  end

  // Counting, line timer, trigger, calibration, overload flash
  logic [cba_pkg::CNT_W-1:0] low_q, low_d;   // Fast 8-bit counter
  logic [cba_pkg::EXT_W-1:0] ext_q, ext_d;   // Extension, counts down
  logic [TW-1:0]             line_q, line_d; // Line period left
  logic                      done_d;         // Line period end
  logic [24:0]               fl_q, fl_d;     // Flash half period timer
  logic                      led_q, led_d;   // Indicator level
  logic                      clr_q, clr_d;   // Trigger clear level
  logic                      cal_q, cal_d;   // Captured jumper
  logic                      eom_q, eom_d;   // Inverted end pulse
  logic [cba_pkg::EXT_W-1:0] ext_neg;        // Wraps counted so far

  always_comb begin
    low_d  = low_q;
    ext_d  = ext_q;
    line_d = line_q;
    done_d = 1'b0;
    fl_d   = fl_q;
    led_d  = led_q;
    if (phase_start)
    begin
      low_d = '0;   // Counters restart each phase
      ext_d = '0;
    end
    else if (lnk.count_pulse)
    begin
      low_d = low_q + cba_pkg::CNT_W'(1);
      if (low_q == '1)
        ext_d = ext_q - cba_pkg::EXT_W'(1);  // 256 counts taken
    end
    // Charge-balance phase lasts one mains period
    if (phase_start && cb_timed)
      line_d = line_50hz ? TW'(LINE50_CYC) : TW'(LINE60_CYC);
    else if (line_q != '0)
    begin
      line_d = line_q - TW'(1);
      done_d = (line_q == TW'(1));
    end
    // Flash while the source is over its limit
    if (!lnk.source_overload_in)
    begin
      fl_d  = '0;
      led_d = 1'b0;
    end
    else if (fl_q >= 25'(FLASH_CYC - 1))
    begin
      fl_d  = '0;
      led_d = !led_q;
    end
    else
      fl_d = fl_q + 25'(1);
    // Clear is held off in cal so the line can sense the jumper
    clr_d = trig_ack && !cal_mode;
    cal_d = cal_mode ? cal_jumper : cal_q;
    eom_d = !measure_done;
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n)
    begin
      low_q  <= '0;
      ext_q  <= '0;
      line_q <= '0;
      cb_done <= 1'b0;
      fl_q   <= '0;
      led_q  <= 1'b0;
      clr_q  <= 1'b0;
      cal_q  <= 1'b0;
      eom_q  <= 1'b1;
    end
    else
    begin
      low_q  <= low_d;
      ext_q  <= ext_d;
      line_q <= line_d;
      cb_done <= done_d;
      fl_q   <= fl_d;
      led_q  <= led_d;
      clr_q  <= clr_d;
      cal_q  <= cal_d;
      eom_q  <= eom_d;
    end
  end

  assign ext_neg                = '0 - ext_q;
  assign phase_count            = {ext_neg, low_q};
  assign cb_active              = (line_q != '0);
  assign trig_seen              = lnk.trigger_sense_in;
  assign lnk.trigger_clear_out  = clr_q;
  assign cal_enabled            = cal_q;
  assign end_of_measure_out     = eom_q;
  assign source_led             = led_q;
endmodule : cba_host

// [cba_link_chk.sv]
/*
  Protocol checker for the signals of cba_link_if.
  Assumes both ends run on mclk with a shared active-low reset.
*/
`timescale 1ns/1ps
module cba_link_chk #(
  parameter int ONE_CYC    = 1900, // Long bit width
  parameter int STROBE_CYC = 2200  // Strobe width
) (
  input wire logic mclk,               // Clock
  input wire logic rst_n,              // Reset, active low
  input wire logic ctrl_link_line_a,   // Pulse line
  input wire logic ctrl_link_line_b,   // Target select
  input wire logic count_pulse,        // Count pulses
  input wire logic trigger_sense_in,   // Trigger latch
  input wire logic trigger_clear_out,  // Latch clear
  input wire logic source_overload_in  // Overload flag
);
  logic [15:0] hi_q, hi_d, lo_q, lo_d, w_q, w_d; // High run, low run, last width
  // Low run saturates so a long idle never reads as a short gap
  always_comb
  begin
    hi_d = ctrl_link_line_a ? hi_q + 16'h0001 : 16'h0000;
    lo_d = ctrl_link_line_a ? 16'h0000 : ((lo_q == 16'hFFFF) ? lo_q : lo_q + 16'h0001);
    w_d  = (!ctrl_link_line_a && hi_q != 16'h0000) ? hi_q : w_q;
  end
  // Reset looks like the tail of a strobe, so the first frame is legal
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      hi_q <= 16'h0000;
      lo_q <= 16'hFFFF;
      w_q  <= 16'(STROBE_CYC);
    end
    else
    begin
      hi_q <= hi_d;
      lo_q <= lo_d;
      w_q  <= w_d;
    end
  end
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);
  pulse_width_a: assert property ($fell(ctrl_link_line_a) |->
    hi_q inside {cba_pkg::ZERO_CYC, ONE_CYC, STROBE_CYC}) else $error("bad pulse width");
  pulse_max_a: assert property (ctrl_link_line_a |-> hi_q < STROBE_CYC) else $error("pulse too long");
  idle_gap_a: assert property ($rose(ctrl_link_line_a) |-> lo_q >= cba_pkg::ZERO_CYC) else $error("gap short");
  target_hold_a: assert property (ctrl_link_line_a && $past(ctrl_link_line_a) |->
    $stable(ctrl_link_line_b)) else $error("target moved in pulse");
  frame_order_a: assert property ($changed(ctrl_link_line_b) |-> w_q == STROBE_CYC)
    else $error("target moved before strobe");
  count_space_a: assert property (count_pulse |=> !count_pulse [*7]) else $error("count spacing");
  trig_hold_a: assert property (trigger_sense_in && !trigger_clear_out |=> trigger_sense_in)
    else $error("trigger lost");
  trig_clear_a: assert property ($fell(trigger_sense_in) |-> $past(trigger_clear_out))
    else $error("trigger dropped uncleared");
endmodule : cba_link_chk

// [cba_link_if.sv]
/*
  Isolated link between the converter sequencer and its host.
  Every signal has one driver; no bidirectional lines.
*/
`timescale 1ns/1ps
interface cba_link_if;
  logic ctrl_link_line_a;    // Pulse-width coded bits and strobe
  logic ctrl_link_line_b;    // Target level: high selects DAC word
  logic count_pulse;         // One pulse per counted tap period
  logic trigger_sense_in;    // Latched external trigger
  logic trigger_clear_out;   // Host clears the trigger latch
  logic source_overload_in;  // Source current over limit

  modport dev (
    input  ctrl_link_line_a, ctrl_link_line_b, trigger_clear_out,
    output count_pulse, trigger_sense_in, source_overload_in
  );
  modport host (
    output ctrl_link_line_a, ctrl_link_line_b, trigger_clear_out,
    input  count_pulse, trigger_sense_in, source_overload_in
  );
endinterface : cba_link_if

// [cba_pkg.sv]
/*
  Shared constants for the charge-balance converter sequencer and its host
  link master: timing, control word layout, divider taps and phase codes.
  Assumes a 100 MHz mclk on both ends.
*/
package cba_pkg;
  // Clock period in ns
  localparam int CLK_NS         = 10;
  // Pulse widths on the control link, in ns
  localparam int T_ZERO_NS      = 18000;
  localparam int T_ONE_NS       = 50000;
  localparam int T_STROBE_NS    = 200000;
  // Mains period, in ns
  localparam int T_LINE60_NS    = 16670000;
  localparam int T_LINE50_NS    = 20000000;
  // Derived cycle counts; exact at 100 MHz
  localparam int ZERO_CYC       = T_ZERO_NS / CLK_NS;
  localparam int ONE_CYC        = T_ONE_NS / CLK_NS;
  localparam int STROBE_CYC     = T_STROBE_NS / CLK_NS;
  localparam int LINE60_CYC     = T_LINE60_NS / CLK_NS;
  localparam int LINE50_CYC     = T_LINE50_NS / CLK_NS;
  // Receiver decision points, midway between legal widths
  localparam int ONE_MIN_CYC    = (ZERO_CYC + ONE_CYC) / 2;
  localparam int STROBE_MIN_CYC = (ONE_CYC + STROBE_CYC) / 2;
  // Pulse width counter size
  localparam int WCNT_W         = 16;
  // Word sizes on the link
  localparam int CTRL_W         = 16;
  localparam int DAC_W          = 12;
  localparam int NBITS_W        = 5;
  // Control word fields
  localparam int F_PHASE_LSB    = 0;
  localparam int F_PHASE_W      = 2;
  localparam int F_ENABLE       = 2;
  localparam int F_SSLOPE       = 3;
  localparam int F_GAIN_LSB     = 4;
  localparam int F_GAIN_W       = 4;
  localparam int F_RANGE_LSB    = 8;
  localparam int F_RANGE_W      = 8;
  // Control word after reset: common phase, input off
  localparam logic [15:0] CTRL_RESET = 16'h0000;
  // Divider: first tap bit, divider width
  localparam int TAP_BASE       = 2;
  localparam int DIV_W          = 8;
  // Measurement phase selection
  typedef enum logic [1:0] {
    CBA_PH_COMMON = 2'h0,
    CBA_PH_REF    = 2'h1,
    CBA_PH_SIGNAL = 2'h3
  } cba_phase_t;
  // Host count widths
  localparam int CNT_W          = 8;
  localparam int EXT_W          = 16;
endpackage : cba_pkg

// [tb.sv]
/*
  Testbench: host and converter joined by cba_link_if, driven on user sides.
  Assumes shortened link and line timings set by parameters below.
*/
`timescale 1ns/1ps
module tb;
  logic mclk = 1'b0, rst_n = 1'b0, cmd_valid = 1'b0, cmd_dac = 1'b0, phase_start = 1'b0;
  logic cb_timed = 1'b0, line_50hz = 1'b0, trig_ack = 1'b0, cal_mode = 1'b0, cal_jumper = 1'b0;
  logic measure_done = 1'b0, cb_comp = 1'b0, ss_pos = 1'b0, trig_n = 1'b1, ovl = 1'b0;
  logic [15:0] cmd_data = 16'h0000; // Word to send
  logic cmd_ready, cb_active, cb_done, trig_seen, cal_enabled, eom, led, cb_inject, in_con, ss_on;
  logic werr;
  logic [23:0] phase_count; // Host count
  logic [1:0]  mux_sel;     // Phase select
  logic [3:0]  gain_sel;    // Gain
  logic [7:0]  relays;      // Relays
  logic [11:0] dac;         // DAC word
  int miscompares = 0, n_compared = 0, n_pulse = 0, c, n_done = 0, n_inj = 0, n_werr = 0;
  // Bench timing; the 50 Hz period is long enough for the 8-bit count to wrap
  localparam int ONE_T = 1900, STR_T = 2200, L60_T = 2000, L50_T = 3400, FL_T = 20;
  always #5 mclk = ~mclk;
  cba_link_if lnk ();
  cba_host #(.ONE_CYC(ONE_T), .STROBE_CYC(STR_T), .LINE60_CYC(L60_T), .LINE50_CYC(L50_T),
    .FLASH_CYC(FL_T)) i_cba_host (.mclk, .rst_n, .lnk(lnk), .cmd_valid, .cmd_ready, .cmd_dac,
    .cmd_data, .phase_start, .cb_timed, .line_50hz, .cb_active, .cb_done, .phase_count,
    .trig_ack, .trig_seen, .cal_mode, .cal_jumper, .cal_enabled, .measure_done,
    .end_of_measure_out(eom), .source_led(led));
  cba_device #(.ONE_MIN_CYC((cba_pkg::ZERO_CYC + ONE_T) / 2),
    .STROBE_MIN_CYC((ONE_T + STR_T) / 2)) i_cba_device (.mclk, .rst_n,
    .lnk(lnk), .cb_comp_above(cb_comp), .ss_comp_positive(ss_pos), .ext_trigger_n(trig_n),
    .overload_detect(ovl), .cb_inject, .input_connect(in_con), .ss_current_on(ss_on), .mux_sel,
    .gain_sel, .range_relays(relays), .dac_code(dac), .word_error(werr));
  cba_link_chk #(.ONE_CYC(ONE_T), .STROBE_CYC(STR_T)) i_cba_link_chk (.mclk, .rst_n,
    .ctrl_link_line_a(lnk.ctrl_link_line_a), .ctrl_link_line_b(lnk.ctrl_link_line_b),
    .count_pulse(lnk.count_pulse), .trigger_sense_in(lnk.trigger_sense_in),
    .trigger_clear_out(lnk.trigger_clear_out), .source_overload_in(lnk.source_overload_in));
  // Own tally of pulses on the wire
  always @(posedge mclk) if (lnk.count_pulse === 1'b1) n_pulse++;
  // Line period ends, injection seen, and any malformed word out of reset
  always @(posedge mclk) if (cb_done === 1'b1) n_done++;
  always @(posedge mclk) if (cb_inject === 1'b1) n_inj++;
  always @(posedge mclk) if (rst_n === 1'b1 && werr !== 1'b0) n_werr++;
  task chk(input logic [23:0] got, input logic [23:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      miscompares++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task cyc(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask : cyc
  // Offer one word, then wait for the serialiser to go idle again
  task send(input logic tgt, input logic [15:0] d);
    int k;
    k = 0;
    cmd_dac = tgt; cmd_data = d; cmd_valid = 1'b1;
    cyc(1);
    cmd_valid = 1'b0;
    while (cmd_ready !== 1'b1 && k < 90000) begin cyc(1); k++; end
    if (k >= 90000) miscompares++;
    cyc(2);
  endtask : send
  // Timed charge-balance phase; injection only when the comparator is above
  task phase(input logic above, input logic f50, input int lw);
    line_50hz = f50; cb_timed = 1'b1; phase_start = 1'b1;
    cyc(1);
    phase_start = 1'b0; n_pulse = 0; cb_comp = above; c = 0; n_done = 0; n_inj = 0;
    while (cb_active === 1'b1 && c < 5000) begin cyc(1); c++; end
    cb_comp = 1'b0;
    cyc(20);
    chk(c, lw);
    chk(n_pulse != 0, above);
    chk(phase_count, n_pulse);
    chk(n_done, 1);
    chk(n_inj != 0, above);
  endtask : phase
  task final_report;
    $display("compared=%0d mismatches=%0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : final_report
  initial
  begin
    #1500000;
    miscompares++;
    final_report;
  end
  initial
  begin
    cyc(2);
    rst_n = 1'b1;
    chk({eom, mux_sel, in_con, cb_inject, dac}, {1'b1, 2'h0, 1'b0, 1'b0, 12'h000});
    send(1'b0, 16'hA597);
    chk({relays, gain_sel, mux_sel, in_con, ss_on}, {8'hA5, 4'h9, 2'h3, 1'b1, 1'b0});
    send(1'b1, 16'h05A3);
    chk({dac, relays}, {12'h5A3, 8'hA5});
    $display("test link words done");
    phase(1'b0, 1'b0, L60_T);
    phase(1'b1, 1'b0, L60_T);
    phase(1'b1, 1'b1, L50_T);
    chk(phase_count > 24'h0000FF, 1'b1);
    $display("test charge balance done");
    trig_n = 1'b0;
    cyc(1);
    trig_n = 1'b1;
    cyc(5);
    chk(trig_seen, 1'b1);
    cal_mode = 1'b1; trig_ack = 1'b1; cal_jumper = 1'b1;
    cyc(3);
    chk({trig_seen, cal_enabled}, 2'h3);
    cal_mode = 1'b0;
    cyc(3);
    chk(trig_seen, 1'b0);
    trig_ack = 1'b0;
    $display("test trigger done");
    ovl = 1'b1;
    cyc(2);
    chk(lnk.source_overload_in, 1'b1);
    cyc(25);
    chk(led, 1'b1);
    ovl = 1'b0;
    cyc(3);
    chk(led, 1'b0);
    measure_done = 1'b1;
    cyc(1);
    chk(eom, 1'b0);
    measure_done = 1'b0;
    cyc(1);
    chk(eom, 1'b1);
    chk(n_werr, 0);
    $display("test overload and end pulse done");
    final_report;
  end
endmodule : tb
